// ===== design/stp_pkg.sv
// Constants for the serial transceiver powerdown controller.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
//
// Functional notes
// R1: A low shutdown input forces powerdown regardless of keep-awake.
// R2: Powerdown turns off the charge pump and tristates every transmitter.
// R3: Inactivity powerdown acts only with keep-awake low and shutdown high.
// R4: Keep-awake high blocks inactivity powerdown; shutdown still wins.
// R5: Thirty seconds without any input edge powers the device down.
// R6: Any transmitter or receiver input edge wakes the device.
// R7: Every powerdown entry leaves the inactivity timer expired.
// R8: With keep-awake low, shutdown rising alone does not wake the device.
// R9: A keep-awake falling edge restarts the thirty-second timer.
// R10: Level-invalid goes low after over 30 us of invalid levels everywhere.
// R11: Level-invalid goes high 1 us after any valid receiver level.
// R12: Level-invalid only reports; it never changes the power state.
// R13: The level detector runs in every power mode.
// R14: Transmission may resume within 100 us of leaving powerdown.
// R15: Ready falls on powerdown and rises once the pump is good.
// R16: Monitor variant tristates standard receiver outputs in powerdown.
// R17: Far side holds both pins high for always-on, or drives shutdown.
// R18: Far side may wire level-invalid to both control pins.
// R19: Long intervals come from counters with parameterised terminal counts.
// R20: Activity inputs are synchronised and edge-detected before use.

package stp_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned IDLE_TIME_S = 30;
  localparam int unsigned IDLE_CYC = IDLE_TIME_S * CLK_HZ;
  localparam int unsigned INV_TIME_US = 30;
  // Strictly more than the interval, so one extra cycle.
  localparam int unsigned INV_CYC = INV_TIME_US * (CLK_HZ / 1_000_000) + 1;
  localparam int unsigned VLD_TIME_US = 1;
  localparam int unsigned VLD_CYC = VLD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESUME_TIME_US = 100;
  localparam int unsigned RESUME_CYC = RESUME_TIME_US * (CLK_HZ / 1_000_000);

  // ==========================================================================
  // Channel counts
  // ==========================================================================
  localparam int unsigned NUM_TX = 3;
  localparam int unsigned NUM_RX = 5;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int unsigned CTRL_SW_SHUT_BIT = 0;
  localparam int unsigned CTRL_RX_GATE_BIT = 1;
  localparam logic CTRL_SW_SHUT_RST = 1'b0;
  localparam logic CTRL_RX_GATE_RST = 1'b1;
  localparam int unsigned ST_POWERED_BIT = 0;
  localparam int unsigned ST_READY_BIT = 1;
  localparam int unsigned ST_INVALID_N_BIT = 2;
  localparam int unsigned ST_EXPIRED_BIT = 3;
  localparam int unsigned ST_KEEP_AWAKE_BIT = 4;
  localparam int unsigned ST_SHUTDOWN_N_BIT = 5;
  localparam logic INVALID_N_RST = 1'b0;

endpackage : stp_pkg

// ===== design/stp_tmr.sv
// Interval timer: counts enabled cycles up to a terminal count and latches done.
// Assumes the caller clears it to restart and may force it to the done state.
`timescale 1ns/1ps

module stp_tmr #(
  parameter int unsigned TERM = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic force_done,
  input wire logic clear,
  input wire logic run,
  // Status
  output logic done
);

  localparam int unsigned CW = $clog2(TERM + 1);
  localparam logic [CW-1:0] LAST = CW'(TERM - 1);

  logic [CW-1:0] count;
  wire at_last = (count == LAST);

  // Force wins over clear so that a powerdown entry is never undone.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear || force_done) begin
      count <= '0;
    end else if (run && !done) begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else if (force_done) begin
      done <= 1'b1;
    end else if (clear) begin
      done <= 1'b0;
    end else if (run && at_last) begin
      done <= 1'b1;
    end
  end

endmodule : stp_tmr

// ===== design/stp_ctrl.sv
// Powerdown controller of a multi-channel serial line transceiver.
// Assumes control pins and line inputs arrive in the clk_sys domain, and an
// APB master for the small control and status register pair.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps

module stp_ctrl
  import stp_pkg::*;
#(
  parameter int unsigned N_TX = stp_pkg::NUM_TX,
  parameter int unsigned N_RX = stp_pkg::NUM_RX,
  parameter int unsigned IDLE_TERM = stp_pkg::IDLE_CYC,
  parameter int unsigned INV_TERM = stp_pkg::INV_CYC,
  parameter int unsigned VLD_TERM = stp_pkg::VLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control pins
  input wire logic shutdown_n_in,
  input wire logic keep_awake_in,
  // Line activity and level sensing
  input wire logic [N_TX-1:0] tx_data_in,
  input wire logic [N_RX-1:0] rx_data_in,
  input wire logic [N_RX-1:0] rx_level_valid,
  input wire logic pump_good,
  // Power and output controls
  output logic pump_en,
  output logic [N_TX-1:0] tx_oe,
  output logic rx_oe,
  output logic invalid_n,
  output logic ready,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  import stp_pkg::*;

  // ==========================================================================
  // Activity synchronisers and edge detection
  // ==========================================================================
  localparam int unsigned NA = N_TX + N_RX;

  logic [NA-1:0] act_s1;
  logic [NA-1:0] act_s2;
  logic [NA-1:0] act_s3;
  logic ka_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      act_s1 <= '0;
      act_s2 <= '0;
      act_s3 <= '0;
    end else begin
      act_s1 <= {tx_data_in, rx_data_in};  // [R20]
      act_s2 <= act_s1;
      act_s3 <= act_s2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ka_q <= 1'b0;
    end else begin
      ka_q <= keep_awake_in;
    end
  end

  wire any_edge = |(act_s2 ^ act_s3);  // [R20]
  wire ka_fall = ka_q && !keep_awake_in;

  // ==========================================================================
  // Control register and effective shutdown
  // ==========================================================================
  logic sw_shut;
  logic rx_gate_en;

  wire shut_eff = shutdown_n_in && !sw_shut;

  // ==========================================================================
  // Inactivity timer
  // ==========================================================================
  logic idle_done;

  // Shutdown low keeps the timer expired; an edge or keep-awake restarts it.
  wire idle_force = !shut_eff;  // [R7] [R8]
  wire idle_clear = any_edge || keep_awake_in || ka_fall;  // [R6] [R9] [R4]

  stp_tmr #(
    .TERM(IDLE_TERM)  // [R19]
  ) u_idle (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .force_done(idle_force),
    .clear(idle_clear),
    .run(1'b1),
    .done(idle_done)  // [R5]
  );

  // ==========================================================================
  // Power decision
  // ==========================================================================
  // Shutdown dominates; keep-awake masks the expired timer only. The
  // level-invalid flag is deliberately absent from this equation.
  wire auto_pd = !keep_awake_in && idle_done;  // [R3] [R4] [R12]
  wire next_powered = shut_eff && !auto_pd;  // [R1] [R3]

  // Outputs follow the decision directly, so transmission is re-enabled on
  // the cycle after wake, far inside the resume allowance.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pump_en <= 1'b0;
      tx_oe <= '0;
      rx_oe <= 1'b0;
    end else begin
      pump_en <= next_powered;  // [R2] [R14]
      tx_oe <= {N_TX{next_powered}};  // [R2]
      rx_oe <= next_powered || !rx_gate_en;  // [R16]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ready <= 1'b0;
    end else begin
      ready <= next_powered && pump_good;  // [R15]
    end
  end

  // ==========================================================================
  // Level-invalid detector
  // ==========================================================================
  wire all_invalid = ~|rx_level_valid;
  logic inv_done;
  logic vld_done;

  // Both timers run regardless of the power state.
  stp_tmr #(
    .TERM(INV_TERM)  // [R19]
  ) u_inv (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .force_done(1'b0),
    .clear(!all_invalid),
    .run(1'b1),  // [R13]
    .done(inv_done)
  );

  stp_tmr #(
    .TERM(VLD_TERM)
  ) u_vld (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .force_done(1'b0),
    .clear(all_invalid),
    .run(1'b1),  // [R13]
    .done(vld_done)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      invalid_n <= INVALID_N_RST;
    end else if (inv_done) begin
      invalid_n <= 1'b0;  // [R10]
    end else if (vld_done) begin
      invalid_n <= 1'b1;  // [R11]
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_status = (paddr == STATUS_OFS);
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire bad_acc = !hit_ctrl && !(hit_status && !pwrite);
  wire ctrl_wr = access && pwrite && hit_ctrl;

  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] next_rdata;

  always_comb begin
    status_word = '0;
    status_word[ST_POWERED_BIT] = pump_en;
    status_word[ST_READY_BIT] = ready;
    status_word[ST_INVALID_N_BIT] = invalid_n;
    status_word[ST_EXPIRED_BIT] = idle_done;
    status_word[ST_KEEP_AWAKE_BIT] = keep_awake_in;
    status_word[ST_SHUTDOWN_N_BIT] = shutdown_n_in;
    ctrl_word = '0;
    ctrl_word[CTRL_SW_SHUT_BIT] = sw_shut;
    ctrl_word[CTRL_RX_GATE_BIT] = rx_gate_en;
    next_rdata = '0;
    if (hit_ctrl) begin
      next_rdata = ctrl_word;
    end else if (hit_status) begin
      next_rdata = status_word;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access && bad_acc;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sw_shut <= CTRL_SW_SHUT_RST;
      rx_gate_en <= CTRL_RX_GATE_RST;
    end else if (ctrl_wr) begin
      sw_shut <= pwdata[CTRL_SW_SHUT_BIT];
      rx_gate_en <= pwdata[CTRL_RX_GATE_BIT];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_edge_while_on;
    any_edge && shut_eff ##1 shut_eff;
  endsequence

  sequence s_all_bad_run;
    all_invalid [*8];
  endsequence

  a_shutdown_wins: assert property ( // [R1]
    !shut_eff |=> !pump_en && !ready)
    else $error("shutdown low did not power down");

  a_pd_tristate: assert property ( // [R2]
    !pump_en |-> (tx_oe == '0))
    else $error("transmitters driven while powered down");

  a_auto_gate: assert property ( // [R3]
    shut_eff && !keep_awake_in && idle_done |=> !pump_en)
    else $error("expired timer did not power down");

  a_keep_awake_on: assert property ( // [R4]
    shut_eff && keep_awake_in |=> pump_en && tx_oe == {N_TX{1'b1}})
    else $error("keep-awake did not hold power on");

  a_edge_wakes: assert property ( // [R6]
    s_edge_while_on |=> pump_en)
    else $error("input edge did not wake the device");

  a_pd_expired: assert property ( // [R7]
    !shut_eff |=> idle_done)
    else $error("timer not expired after powerdown entry");

  a_no_lone_wake: assert property ( // [R8]
    !keep_awake_in && idle_done && !any_edge && !ka_fall
      |=> idle_done && !pump_en)
    else $error("woke without keep-awake or edge");

  a_ka_restart: assert property ( // [R9]
    ka_fall && shut_eff ##1 shut_eff |=> !idle_done && pump_en)
    else $error("keep-awake fall did not restart timer");

  a_inv_low: assert property ( // [R10]
    $fell(invalid_n) |-> $past(all_invalid) && $past(inv_done))
    else $error("level-invalid fell without its interval");

  a_inv_short: assert property ( // [R10]
    !all_invalid ##1 s_all_bad_run |-> !inv_done)
    else $error("level-invalid timer too short");

  a_inv_high: assert property ( // [R11]
    vld_done && !inv_done |=> invalid_n)
    else $error("level-invalid did not rise after valid level");

  a_ready_low: assert property ( // [R15]
    !next_powered |=> !ready ##0 !pump_en)
    else $error("ready high during powerdown");

  a_rx_gate: assert property ( // [R16]
    rx_gate_en && !next_powered |=> !rx_oe)
    else $error("receiver outputs driven in powerdown");

endmodule : stp_ctrl

// ===== verif/stp_host.sv
// Host power manager model that drives the two control pins.
// Assumes the bench picks the mode; pins change just after clk_sys rises.
`timescale 1ns/1ps

module stp_host (
  // Clock
  input wire logic clk_sys,
  // Bench mode and device status
  input wire logic [1:0] mode,
  input wire logic invalid_n,
  // Control pins
  output logic shutdown_n_in,
  output logic keep_awake_in
);
  // Modes: 0 automatic, 1 always on, 2 forced off, 3 level driven.
  initial begin
    shutdown_n_in = 1'b1;
    keep_awake_in = 1'b0;
  end
  always @(posedge clk_sys) begin
    case (mode)
      2'h0: {shutdown_n_in, keep_awake_in} <= 2'h2;
      2'h1: {shutdown_n_in, keep_awake_in} <= 2'h3;
      2'h2: {shutdown_n_in, keep_awake_in} <= 2'h0;
      default: {shutdown_n_in, keep_awake_in} <= {2{invalid_n}};
    endcase
  end
endmodule : stp_host

// ===== verif/tb_stp_ctrl.sv
// Bench for the powerdown controller: pins, timers, level sense, APB.
// Assumes the host model drives the pins and the bench all other inputs.
`timescale 1ns/1ps

module tb_stp_ctrl;
  import stp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] mode = 2'h1;
  logic [2:0] tx = 3'h0;
  logic [4:0] rx = 5'h00;
  logic [4:0] vld = 5'h1f;
  logic pump_good = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic shut_n, keep, pump_en, rx_oe, invalid_n, ready, pready, pslverr;
  logic [2:0] tx_oe;
  logic [31:0] prdata;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  stp_ctrl #(.IDLE_TERM(50)) stp_ctrl_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .shutdown_n_in(shut_n),
    .keep_awake_in(keep), .tx_data_in(tx), .rx_data_in(rx),
    .rx_level_valid(vld), .pump_good(pump_good), .pump_en(pump_en),
    .tx_oe(tx_oe), .rx_oe(rx_oe), .invalid_n(invalid_n), .ready(ready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  stp_host stp_host_i (.clk_sys(clk_sys), .mode(mode),
    .invalid_n(invalid_n), .shutdown_n_in(shut_n), .keep_awake_in(keep));

  always #50 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic summarize;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Lets n edges pass, then samples at the following falling edge.
  task automatic at(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : at

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    logic [31:0] rd;
    logic err;
    at(0);
    chk("pump_en", 0, pump_en);
    at(1);
    chk("pump_en", 1, pump_en);
    apb(1'b0, CTRL_OFS, 0, rd, err);
    chk("ctrl", 32'h0000_0002, rd);
  endtask : t_reset

  task automatic t_force;
    @(posedge clk_sys);
    mode <= 2'h2;
    at(3);
    chk("pump_en", 0, pump_en);
    chk("tx_oe", 0, tx_oe);
    chk("rx_oe", 0, rx_oe);
    chk("ready", 0, ready);
    @(posedge clk_sys);
    tx <= 3'h5;
    at(8);
    chk("pump_en", 0, pump_en);
  endtask : t_force

  task automatic t_wake;
    @(posedge clk_sys);
    mode <= 2'h0;
    pump_good <= 1'b0;
    at(20);
    chk("pump_en", 0, pump_en);
    @(posedge clk_sys);
    tx <= 3'h1;
    at(5);
    chk("pump_en", 1, pump_en);
    chk("tx_oe", 3'h7, tx_oe);
    chk("ready", 0, ready);
    @(posedge clk_sys);
    pump_good <= 1'b1;
    at(2);
    chk("ready", 1, ready);
    at(35);
    chk("pump_en", 1, pump_en);
    at(20);
    chk("pump_en", 0, pump_en);
    chk("tx_oe", 0, tx_oe);
    at(30);
    chk("pump_en", 0, pump_en);
    @(posedge clk_sys);
    rx <= 5'h10;
    at(5);
    chk("pump_en", 1, pump_en);
  endtask : t_wake

  task automatic t_keep;
    @(posedge clk_sys);
    mode <= 2'h1;
    at(200);
    chk("pump_en", 1, pump_en);
    mode <= 2'h0;
    at(40);
    chk("pump_en", 1, pump_en);
    at(20);
    chk("pump_en", 0, pump_en);
  endtask : t_keep

  task automatic t_level;
    @(posedge clk_sys);
    mode <= 2'h1;
    vld <= 5'h00;
    at(295);
    chk("invalid_n", 1, invalid_n);
    at(10);
    chk("invalid_n", 0, invalid_n);
    chk("pump_en", 1, pump_en);
    @(posedge clk_sys);
    mode <= 2'h2;
    vld <= 5'h01;
    at(5);
    chk("invalid_n", 0, invalid_n);
    at(10);
    chk("invalid_n", 1, invalid_n);
  endtask : t_level

  task automatic t_wired;
    @(posedge clk_sys);
    mode <= 2'h3;
    vld <= 5'h1f;
    at(5);
    chk("pump_en", 1, pump_en);
    @(posedge clk_sys);
    vld <= 5'h00;
    at(310);
    chk("pump_en", 0, pump_en);
    @(posedge clk_sys);
    vld <= 5'h1f;
    at(16);
    chk("pump_en", 1, pump_en);
  endtask : t_wired

  task automatic t_apb;
    logic [31:0] rd;
    logic err;
    @(posedge clk_sys);
    mode <= 2'h1;
    apb(1'b1, CTRL_OFS, 32'h0000_0003, rd, err);
    chk("pslverr", 0, err);
    at(3);
    chk("pump_en", 0, pump_en);
    chk("rx_oe", 0, rx_oe);
    apb(1'b0, STATUS_OFS, 0, rd, err);
    chk("status", 32'h0000_0034, rd & 32'h0000_0037);
    apb(1'b1, CTRL_OFS, 32'h0000_0001, rd, err);
    at(3);
    chk("rx_oe", 1, rx_oe);
    apb(1'b1, CTRL_OFS, 32'h0000_0002, rd, err);
    at(3);
    chk("pump_en", 1, pump_en);
    apb(1'b1, STATUS_OFS, 32'h0000_0000, rd, err);
    chk("pslverr", 1, err);
    apb(1'b0, 8'h08, 0, rd, err);
    chk("pslverr", 1, err);
    chk("prdata", 0, rd);
    chk("pready", 1, pready);
  endtask : t_apb

  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_force();
    t_wake();
    t_keep();
    t_level();
    t_wired();
    t_apb();
    summarize();
  end
endmodule : tb_stp_ctrl
